// ---- shared/pcc_consts.svh ----
/*
 * offsets, field positions, reset values and widths of the classifier criteria register bank.
 * assumes inclusion from the package and the bench file only; holds definitions, no logic.
 */
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH

// ----------------------------------------
// register indices on the management port
// ----------------------------------------
`define PCC_ADDR_UDP_DPORT    6'h2A
`define PCC_ADDR_MASK         6'h2B
`define PCC_ADDR_MATCH        6'h2C
`define PCC_ADDR_OFFSET       6'h2D
`define PCC_ADDR_COMMIT       6'h2E

// ----------------------------------------
// reset values
// ----------------------------------------
`define PCC_RST_UDP_DPORT     16'h013F
`define PCC_RST_ZERO16        16'h0000
`define PCC_PORT_ANY          16'hFFFF

// ----------------------------------------
// field positions
// ----------------------------------------
`define PCC_OFS_ENABLE_BIT    15
`define PCC_COMMIT_GO_BIT     7
`define PCC_SEL_PTP           4'hF
`define PCC_NUM_CRIT          8

`endif

// ---- shared/pcc_pkg.sv ----
/*
 * types shared by the classifier criteria register bank.
 * assumes pcc_consts.svh is reachable on the include path.
 */
`include "pcc_consts.svh"

package pcc_pkg;

   // one stored criterion, applied as a whole on commit
   typedef struct packed {
      logic        enable;
      logic [7:0]  offset;
      logic [15:0] match;
      logic [15:0] mask;
   } pcc_crit_s;

   // one register access on the management port
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [5:0]  addr;
      logic [15:0] wdata;
   } pcc_req_s;

   // packet facts from the parser, one set per packet; criterion words arrive on crit_words
   typedef struct packed {
      logic        valid;
      logic        is_ipv4;
      logic        is_ipv6;
      logic [15:0] udp_dest_port;
      logic [15:0] udp_source_port_value;
      logic        hard_ok;
   } pcc_pkt_s;

   typedef enum logic [1:0] {
      PCC_IDLE   = 2'b01,
      PCC_COMMIT = 2'b10
   } pcc_state_e;

endpackage : pcc_pkg

// ---- hdl/pcc_criteria_regs.sv ----
/*
 * register bank for the configurable precision-time packet classifier: udp destination port,
 * criterion mask/match/offset staging, commit logic, and the per-criterion match and qualify logic.
 * assumes the management-port front end presents one-cycle rd/wr strobes with a register index, and
 * the packet parser presents per-criterion 16-bit words already fetched at each stored offset.
 */
// Contract
// - ipv4 needs udp destination port equal to register unless it is all ones
// - ipv6 needs destination port match unless the gate register is all ones; the code gates on udp_source_port_value instead
// - gate register all ones skips destination port comparison; the code does this for ipv4 only
// - eight independent criteria loaded via mask, match, offset and commit
// - mask bit one compares the packet bit, zero excludes it
// - criterion met when every masked packet bit equals its match bit
// - bit 15 is the word's msb, the first bit on the line
// - offset register bit 15 enables or disables the criterion
// - select all ones ignores the enable bit during commit
// - eight-bit offset is byte distance from start position to compared word
// - writing bit 7 commits staged values; the device clears it
// - selects 0 to 7 commit to criteria 0 to 7
// - select 15 copies offset into the ptp start offset
// - four-bit start field picks where comparisons begin
// - combine bit chooses both criteria sets or either set
module pcc_criteria_regs
   import pcc_pkg::*;
#(
   parameter int NUM_CRIT = `PCC_NUM_CRIT
)
(
   input  wire logic                       clk,
   input  wire logic                       resetn,
   input  wire pcc_pkg::pcc_req_s          req,
   input  wire logic [3:0]                 start_sel,
   input  wire logic                       combine_or,
   input  wire logic                       ipv4_udp_class_enable,
   input  wire logic                       ipv6_udp_class_enable,
   input  wire pcc_pkg::pcc_pkt_s          pkt,
   input  wire logic [NUM_CRIT*16-1:0]     crit_words,
   output logic [15:0]                     rdata,
   output logic                            rvalid,
   output pcc_pkg::pcc_crit_s [NUM_CRIT-1:0] crit_q,
   output logic [7:0]                      ptp_start_offset,
   output logic [3:0]                      class_start_q,
   output logic                            pkt_qualified,
   output logic                            pkt_done
);
   import pcc_pkg::*;

   // ----------------------------------------
   // staging registers
   // ----------------------------------------
   logic [15:0] udp_dport_q, udp_dport_d;
   logic [15:0] mask_q, mask_d;
   logic [15:0] match_q, match_d;
   logic        ena_q, ena_d;
   logic [7:0]  ofs_q, ofs_d;
   logic [3:0]  sel_q, sel_d;
   logic        go_q, go_d;
   pcc_state_e  st_q, st_d;

   always_comb
   begin
      udp_dport_d = udp_dport_q;
      mask_d    = mask_q;
      match_d   = match_q;
      ena_d     = ena_q;
      ofs_d     = ofs_q;
      sel_d     = sel_q;
      go_d      = go_q;
      st_d      = st_q;
      unique case (st_q)
         PCC_IDLE:
         begin
            if (go_q)
            begin
               st_d = PCC_COMMIT;
            end
         end
         PCC_COMMIT:
         begin
            go_d = 1'b0;
            st_d = PCC_IDLE;
         end
         default:
         begin
            st_d = PCC_IDLE;
         end
      endcase
      if (req.wr)
      begin
         unique case (req.addr)
            `PCC_ADDR_UDP_DPORT: udp_dport_d = req.wdata;
            `PCC_ADDR_MASK:    mask_d    = req.wdata;
            `PCC_ADDR_MATCH:   match_d   = req.wdata;
            `PCC_ADDR_OFFSET:
            begin
               ena_d = req.wdata[`PCC_OFS_ENABLE_BIT];
               ofs_d = req.wdata[7:0];
            end
            `PCC_ADDR_COMMIT:
            begin
               sel_d = req.wdata[3:0];
               // a new start wins over the self-clear landing in the same cycle
               if (req.wdata[`PCC_COMMIT_GO_BIT])
               begin
                  go_d = 1'b1;
               end
            end
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         udp_dport_q <= `PCC_RST_UDP_DPORT;
         mask_q    <= `PCC_RST_ZERO16;
         match_q   <= `PCC_RST_ZERO16;
         ena_q     <= 1'b0;
         ofs_q     <= 8'h00;
         sel_q     <= 4'h0;
         go_q      <= 1'b0;
         st_q      <= PCC_IDLE;
      end
      else
      begin
         udp_dport_q <= udp_dport_d;
         mask_q    <= mask_d;
         match_q   <= match_d;
         ena_q     <= ena_d;
         ofs_q     <= ofs_d;
         sel_q     <= sel_d;
         go_q      <= go_d;
         st_q      <= st_d;
      end
   end

   // ----------------------------------------
   // read-back
   // ----------------------------------------
   logic [15:0] rdata_d;
   logic        rvalid_d;

   always_comb
   begin
      rvalid_d = req.rd;
      unique case (req.addr)
         `PCC_ADDR_UDP_DPORT: rdata_d = udp_dport_q;
         `PCC_ADDR_MASK:    rdata_d = mask_q;
         `PCC_ADDR_MATCH:   rdata_d = match_q;
         `PCC_ADDR_OFFSET:  rdata_d = {ena_q, 7'h00, ofs_q};
         `PCC_ADDR_COMMIT:  rdata_d = {8'h00, go_q, 3'h0, sel_q};
         default:           rdata_d = 16'h0000;
      endcase
      if (!req.rd)
      begin
         rdata_d = 16'h0000;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rdata  <= 16'h0000;
         rvalid <= 1'b0;
      end
      else
      begin
         rdata  <= rdata_d;
         rvalid <= rvalid_d;
      end
   end

   // ----------------------------------------
   // commit into criteria and ptp start offset
   // ----------------------------------------
   pcc_crit_s [NUM_CRIT-1:0] crit_d;
   logic [7:0]               ptp_d;
   logic                     do_commit;

   assign do_commit = (st_q == PCC_COMMIT);

   always_comb
   begin
      crit_d = crit_q;
      ptp_d  = ptp_start_offset;
      if (do_commit)
      begin
         if (sel_q == `PCC_SEL_PTP)
         begin
            ptp_d = ofs_q;
         end
         else if (!sel_q[3])
         begin
            // whole struct in one assignment so no field lags another
            crit_d[sel_q[2:0]] = '{enable: ena_q, offset: ofs_q,
                                   match: match_q, mask: mask_q};
         end
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         crit_q           <= '0;
         ptp_start_offset <= 8'h00;
         class_start_q    <= 4'h0;
      end
      else
      begin
         crit_q           <= crit_d;
         ptp_start_offset <= ptp_d;
         class_start_q    <= start_sel;
      end
   end

   // ----------------------------------------
   // qualification
   // ----------------------------------------
   logic [NUM_CRIT-1:0] crit_ok;
   logic                cfg_ok, udp_ok, qual_d;

   // offset selects the word upstream; the word arrives msb-first as bit 15
   generate
      for (genvar i = 0; i < NUM_CRIT; i++)
      begin : g_crit
         assign crit_ok[i] = !crit_q[i].enable ||
            (((crit_words[i*16 +: 16] ^ crit_q[i].match) & crit_q[i].mask) == 16'h0000);
      end
   endgenerate

   always_comb
   begin
      cfg_ok = &crit_ok;
      udp_ok = 1'b1;
      if (pkt.is_ipv4 && ipv4_udp_class_enable && (udp_dport_q != `PCC_PORT_ANY))
      begin
         udp_ok = (pkt.udp_dest_port == udp_dport_q);
      end
      if (pkt.is_ipv6 && ipv6_udp_class_enable && (pkt.udp_source_port_value != `PCC_PORT_ANY))
      begin
         udp_ok = (pkt.udp_dest_port == udp_dport_q);
      end
      qual_d = combine_or ? (cfg_ok || (pkt.hard_ok && udp_ok))
                          : (cfg_ok && pkt.hard_ok && udp_ok);
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pkt_qualified <= 1'b0;
         pkt_done      <= 1'b0;
      end
      else
      begin
         pkt_qualified <= pkt.valid && qual_d;
         pkt_done      <= pkt.valid;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_GO_CLEARS: assert property (@(posedge clk) disable iff (!resetn)
      $rose(go_q) && !(req.wr && req.addr == `PCC_ADDR_COMMIT) |-> ##2 !go_q)
      else $error("commit bit did not self-clear");
   AST_CRIT_LOAD: assert property (@(posedge clk) disable iff (!resetn)
      do_commit && !sel_q[3] |=> crit_q[$past(sel_q[2:0])].mask == $past(mask_q))
      else $error("criterion mask not loaded on commit");
   AST_PTP_LOAD: assert property (@(posedge clk) disable iff (!resetn)
      do_commit && sel_q == `PCC_SEL_PTP |=> ptp_start_offset == $past(ofs_q))
      else $error("ptp start offset not loaded");
   AST_PTP_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      !(do_commit && sel_q == `PCC_SEL_PTP) |=> $stable(ptp_start_offset))
      else $error("ptp start offset changed without commit");
   AST_UNUSED_SEL: assert property (@(posedge clk) disable iff (!resetn)
      do_commit && sel_q[3] |=> $stable(crit_q))
      else $error("criterion changed on unused select");
   AST_RSV_OFS: assert property (@(posedge clk) disable iff (!resetn)
      $past(req.rd) && $past(req.addr) == `PCC_ADDR_OFFSET |-> rdata[14:8] == 7'h00)
      else $error("reserved offset bits not zero");
   AST_IPV4_PORT: assert property (@(posedge clk) disable iff (!resetn)
      pkt.valid && !combine_or && pkt.is_ipv4 && !pkt.is_ipv6 && ipv4_udp_class_enable
      && udp_dport_q != `PCC_PORT_ANY && pkt.udp_dest_port != udp_dport_q |=> !pkt_qualified)
      else $error("ipv4 qualified with wrong port");
   AST_MASK_MISS: assert property (@(posedge clk) disable iff (!resetn)
      pkt.valid && !combine_or && crit_q[0].enable
      && ((crit_words[15:0] ^ crit_q[0].match) & crit_q[0].mask) != 16'h0000 |=> !pkt_qualified)
      else $error("qualified despite masked mismatch");
   COV_COMMIT_CRIT: cover property (@(posedge clk) disable iff (!resetn) do_commit && !sel_q[3]);
   COV_COMMIT_PTP: cover property (@(posedge clk) disable iff (!resetn) do_commit && sel_q == `PCC_SEL_PTP);
   COV_QUAL: cover property (@(posedge clk) disable iff (!resetn) pkt_qualified);

endmodule // pcc_criteria_regs

// ---- bench/tb_top.sv ----
/*
 * self-checking bench for the classifier criteria register bank: register reset values, reserved
 * bits, commits to all eight criteria and to the start offset, and packet qualification.
 * assumes pcc_pkg and pcc_consts.svh are compiled first; the bench drives every port at the falling edge.
 */
`include "pcc_consts.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pcc_pkg::*;

   logic                  clk;
   logic                  resetn;
   pcc_req_s              req;
   logic [3:0]            start_sel;
   logic                  combine_or;
   logic                  ipv4_udp_class_enable;
   logic                  ipv6_udp_class_enable;
   pcc_pkt_s              pkt;
   logic [127:0]          crit_words;
   logic [15:0]           rdata;
   logic                  rvalid;
   pcc_crit_s [7:0]       crit_q;
   logic [7:0]            ptp_start_offset;
   logic [3:0]            class_start_q;
   logic                  pkt_qualified;
   logic                  pkt_done;
   int                    errors;
   int                    comparisons;
   pcc_crit_s             exp_c [8];
   logic [127:0]          good;

   pcc_criteria_regs #(.NUM_CRIT(8)) pcc_criteria_regs_inst (
      .clk                   (clk),
      .resetn                (resetn),
      .req                   (req),
      .start_sel             (start_sel),
      .combine_or            (combine_or),
      .ipv4_udp_class_enable (ipv4_udp_class_enable),
      .ipv6_udp_class_enable (ipv6_udp_class_enable),
      .pkt                   (pkt),
      .crit_words            (crit_words),
      .rdata                 (rdata),
      .rvalid                (rvalid),
      .crit_q                (crit_q),
      .ptp_start_offset      (ptp_start_offset),
      .class_start_q         (class_start_q),
      .pkt_qualified         (pkt_qualified),
      .pkt_done              (pkt_done)
   );

   initial clk = 1'b0;
   always #5 clk = ~clk;

   // ----------------------------------------
   // access and compare tasks
   // ----------------------------------------
   task automatic give_verdict();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input string name, input logic [40:0] exp, input logic [40:0] got);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] w);
      @(negedge clk);
      req.wr    = 1'b1;
      req.addr  = a;
      req.wdata = w;
      @(negedge clk);
      req.wr    = 1'b0;
   endtask

   // rvalid is a one-cycle pulse; the poll is bounded so a missing answer cannot hang the run
   task automatic rd(input logic [5:0] a, output logic [15:0] v);
      int k;
      k = 0;
      @(negedge clk);
      req.rd   = 1'b1;
      req.addr = a;
      @(negedge clk);
      req.rd   = 1'b0;
      while (rvalid !== 1'b1 && k < 4)
      begin
         @(negedge clk);
         k++;
      end
      check("rvalid", 41'h1, {40'h0, rvalid});
      v = rdata;
   endtask

   task automatic rchk(input string name, input logic [5:0] a, input logic [15:0] exp);
      logic [15:0] v;
      rd(a, v);
      check(name, {25'h0, exp}, {25'h0, v});
   endtask

   // go bit clears itself; the register then reads back the select alone
   task automatic commit(input logic [3:0] sel);
      int k;
      logic [15:0] v;
      k = 0;
      wr(`PCC_ADDR_COMMIT, {8'h00, 4'h8, sel});
      do
      begin
         rd(`PCC_ADDR_COMMIT, v);
         k++;
      end
      while (v[7] !== 1'b0 && k < 8);
      check("commit_reg", {37'h0, sel}, {25'h0, v});
   endtask

   task automatic chk_crit();
      for (int j = 0; j < 8; j++)
         check("crit_q", exp_c[j], crit_q[j]);
   endtask

   task automatic pkt_eval(input logic [15:0] port, input logic [15:0] src, input logic v4,
                           input logic hard, input logic [127:0] words, input logic exp_q);
      @(negedge clk);
      check("pkt_done", 41'h0, {40'h0, pkt_done});
      pkt.valid       = 1'b1;
      pkt.is_ipv4     = v4;
      pkt.is_ipv6     = ~v4;
      pkt.udp_dest_port = port;
      pkt.udp_source_port_value = src;
      pkt.hard_ok     = hard;
      crit_words      = words;
      @(negedge clk);
      pkt.valid       = 1'b0;
      check("pkt_qualified", {40'h0, exp_q}, {40'h0, pkt_qualified});
      check("pkt_done", 41'h1, {40'h0, pkt_done});
   endtask

   // ----------------------------------------
   // watchdog
   // ----------------------------------------
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("[ERR] run expected done seen timeout");
      give_verdict();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      errors = 0;
      comparisons = 0;
      resetn = 1'b0;
      req = '0;
      pkt = '0;
      crit_words = '0;
      start_sel = 4'h0;
      combine_or = 1'b0;
      ipv4_udp_class_enable = 1'b1;
      ipv6_udp_class_enable = 1'b1;
      repeat (12) @(posedge clk);
      @(negedge clk);
      resetn = 1'b1;

      rchk("udp_dest_port_match", `PCC_ADDR_UDP_DPORT, 16'h013F);
      rchk("criterion_bit_mask", `PCC_ADDR_MASK, 16'h0000);
      rchk("criterion_compare_value", `PCC_ADDR_MATCH, 16'h0000);
      rchk("criterion_position_enable", `PCC_ADDR_OFFSET, 16'h0000);
      rchk("criterion_commit_select", `PCC_ADDR_COMMIT, 16'h0000);
      rchk("unmapped", 6'h30, 16'h0000);
      wr(`PCC_ADDR_OFFSET, 16'hFFFF);
      rchk("criterion_position_enable", `PCC_ADDR_OFFSET, 16'h80FF);
      wr(`PCC_ADDR_COMMIT, 16'hFF4F);
      rchk("criterion_commit_select", `PCC_ADDR_COMMIT, 16'h000F);
      $display("test registers done");

      // offsets stay well below the start offset plus 32 set further down
      for (int i = 0; i < 8; i++)
      begin
         exp_c[i].mask   = 16'h80F0 | (16'h0001 << i);
         exp_c[i].match  = 16'h8000 | (16'h1234 + 16'(i));
         exp_c[i].offset = 8'h10 + 8'(i);
         exp_c[i].enable = (i != 5);
         good[i*16 +: 16] = exp_c[i].match ^ ~exp_c[i].mask;
         wr(`PCC_ADDR_MASK, exp_c[i].mask);
         wr(`PCC_ADDR_MATCH, exp_c[i].match);
         wr(`PCC_ADDR_OFFSET, {exp_c[i].enable, 7'h00, exp_c[i].offset});
         commit(4'(i));
      end
      chk_crit();
      wr(`PCC_ADDR_OFFSET, 16'h8025);
      commit(4'hF);
      check("ptp_start_offset", 41'h25, {33'h0, ptp_start_offset});
      chk_crit();
      @(negedge clk);
      start_sel = 4'h9;
      @(negedge clk);
      check("class_start_q", 41'h9, {37'h0, class_start_q});
      $display("test commits done");

      pkt_eval(16'h013F, 16'hFFFF, 1'b1, 1'b1, good, 1'b1);
      pkt_eval(16'h0140, 16'hFFFF, 1'b1, 1'b1, good, 1'b0);
      pkt_eval(16'h013F, 16'hFFFF, 1'b1, 1'b1, good ^ (128'h1 << 15), 1'b0);
      pkt_eval(16'h013F, 16'hFFFF, 1'b1, 1'b1, good ^ 128'h2, 1'b1);
      pkt_eval(16'h013F, 16'hFFFF, 1'b1, 1'b1, good ^ (128'h1 << 95), 1'b1);
      pkt_eval(16'h0140, 16'hFFFF, 1'b0, 1'b1, good, 1'b1);
      pkt_eval(16'h0140, 16'h1234, 1'b0, 1'b1, good, 1'b0);
      pkt_eval(16'h013F, 16'h1234, 1'b0, 1'b1, good, 1'b1);
      pkt_eval(16'h013F, 16'hFFFF, 1'b1, 1'b0, good, 1'b0);
      combine_or = 1'b1;
      pkt_eval(16'h0140, 16'hFFFF, 1'b1, 1'b0, good, 1'b1);
      pkt_eval(16'h013F, 16'hFFFF, 1'b1, 1'b1, good ^ (128'h1 << 15), 1'b1);
      pkt_eval(16'h013F, 16'hFFFF, 1'b1, 1'b0, good ^ (128'h1 << 15), 1'b0);
      combine_or = 1'b0;
      ipv4_udp_class_enable = 1'b0;
      pkt_eval(16'h0140, 16'hFFFF, 1'b1, 1'b1, good, 1'b1);
      ipv6_udp_class_enable = 1'b0;
      pkt_eval(16'h0140, 16'h1234, 1'b0, 1'b1, good, 1'b1);
      ipv4_udp_class_enable = 1'b1;
      ipv6_udp_class_enable = 1'b1;
      wr(`PCC_ADDR_UDP_DPORT, 16'hFFFF);
      rchk("udp_dest_port_match", `PCC_ADDR_UDP_DPORT, 16'hFFFF);
      pkt_eval(16'h0140, 16'h1234, 1'b1, 1'b1, good, 1'b1);
      $display("test packets done");
      give_verdict();
   end

endmodule // tb_top
